// *** src/lim_irq_ctrl.sv ***
// Level mask, global control register, request register and acknowledge gate
`default_nettype none

module lim_irq_ctrl #(
	parameter int NSRC = lim_pkg::NUM_SOURCES,
	parameter int NLVL = lim_pkg::NUM_LEVELS
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Register file port of the core, set 1
	input  wire logic [7:0]       reg_addr,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	output logic                  reg_hit,
	// Instruction events from the core
	input  wire logic             irq_enable_instr,
	input  wire logic             irq_disable_instr,
	input  wire logic             irq_return_instr,
	// Sources and their enables from peripheral control registers
	input  wire logic [NSRC-1:0]  src_req,
	input  wire logic [NSRC-1:0]  src_en,
	// Winning level from the priority logic
	input  wire logic [NLVL-1:0]  level_win,
	// Core side of acceptance
	input  wire logic             instr_end,
	output logic                  irq_take,
	output logic      [4:0]       irq_src,
	output logic                  irq_fast,
	output logic      [NLVL-1:0]  level_service,
	output logic                  global_enable,
	output logic                  fast_enable,
	output logic      [2:0]       fast_level
);
	////////////////////////////////////////////////////////////////////////
	// Register select; reg_sel decodes once into wr_sel for the write strobes and again inside the read mux
	typedef enum logic [1:0] {
		LIM_SEL_NONE,
		LIM_SEL_REQ,
		LIM_SEL_MASK,
		LIM_SEL_CTRL
	} lim_sel_t;

	// Action on the global enable bit; the fourth code is never produced
	typedef enum logic [1:0] {
		LIM_GIE_KEEP,
		LIM_GIE_SET,
		LIM_GIE_CLEAR
	} lim_gie_t;

	logic [7:0]      level_mask_reg;
	logic [7:0]      global_irq_control_reg;
	logic [NLVL-1:0] level_req_reg;
	logic [7:0]      next_level_mask_reg;
	logic [7:0]      next_global_irq_control_reg;
	logic [NLVL-1:0] next_level_req_reg;
	logic [NLVL-1:0] level_req;
	logic [NLVL-1:0] level_ok;
	logic [NSRC-1:0] src_live;
	logic [2:0]      win_level;
	logic            win_any;
	logic            pick_found;
	logic            wr_mask;
	logic            wr_ctrl;
	logic [NLVL-1:0] level_cand;
	logic [NLVL-1:0] level_fast;
	logic [7:0]      rd_req_val;
	logic [7:0]      rd_mask_val;
	logic [7:0]      rd_ctrl_val;
	lim_sel_t        wr_sel;
	lim_gie_t        gie_action;

	function automatic logic [2:0] lowest_set(input logic [NLVL-1:0] v);
		lowest_set = 3'h0;
		for (int i = NLVL - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowest_set = 3'(i);
			end
		end
	endfunction : lowest_set

	function automatic lim_sel_t reg_sel(input logic [7:0] a);
		if (a == lim_pkg::ADDR_REQ) begin
			reg_sel = LIM_SEL_REQ;
		end else if (a == lim_pkg::ADDR_MASK) begin
			reg_sel = LIM_SEL_MASK;
		end else if (a == lim_pkg::ADDR_CTRL) begin
			reg_sel = LIM_SEL_CTRL;
		end else begin
			reg_sel = LIM_SEL_NONE;
		end
	endfunction : reg_sel

	////////////////////////////////////////////////////////////////////////
	lim_level_map #(
		.NSRC (NSRC),
		.NLVL (NLVL)
	) u_map (
		.src_req   (src_req),
		.src_en    (src_en),
		.level_req (level_req)
	);

	assign src_live = src_req & src_en;

	lim_src_pick #(
		.NSRC (NSRC)
	) u_pick (
		.src_live (src_live),
		.level    (win_level),
		.src_idx  (irq_src),
		.found    (pick_found)
	);

	////////////////////////////////////////////////////////////////////////
	assign wr_sel  = reg_sel(reg_addr);
	assign wr_mask = reg_wr && (wr_sel == LIM_SEL_MASK);
	assign wr_ctrl = reg_wr && (wr_sel == LIM_SEL_CTRL);

	assign global_enable = global_irq_control_reg[lim_pkg::CTRL_GIE];
	assign fast_enable   = global_irq_control_reg[lim_pkg::CTRL_FIE];
	assign fast_level    = global_irq_control_reg[lim_pkg::CTRL_FLV_HI:lim_pkg::CTRL_FLV_LO];

	for (genvar l = 0; l < NLVL; l++) begin : g_level
		assign level_ok[l]   = level_req[l] && level_mask_reg[l];
		assign level_cand[l] = level_ok[l] && level_win[l];
		assign level_fast[l] = fast_enable && (fast_level == 3'(l));
	end

	assign win_level     = lowest_set(level_cand);
	assign win_any       = |level_cand;
	assign level_service = level_ok;

	assign irq_take = instr_end && global_enable && win_any && pick_found;
	// Fast service applies only to the level that actually wins
	assign irq_fast = irq_take && level_fast[win_level];

	////////////////////////////////////////////////////////////////////////
	// instruction and accept priority
	always_comb begin
		gie_action = LIM_GIE_KEEP;
		if (irq_disable_instr || irq_take) begin
			gie_action = LIM_GIE_CLEAR;
		end
		// Set wins so an enable is never lost to a same-cycle accept
		if (irq_enable_instr || irq_return_instr) begin
			gie_action = LIM_GIE_SET;
		end
	end

	always_comb begin
		next_level_mask_reg = level_mask_reg;
		if (wr_mask) begin
			next_level_mask_reg = reg_wdata;
		end
	end

	// Mask has no reset on purpose: software must program it
	always_ff @(posedge core_clk) begin
		level_mask_reg <= next_level_mask_reg;
	end

	always_comb begin
		next_global_irq_control_reg = global_irq_control_reg;
		if (wr_ctrl) begin
			next_global_irq_control_reg = reg_wdata & lim_pkg::CTRL_MASK;
		end
		unique case (gie_action)
			LIM_GIE_SET: begin
				next_global_irq_control_reg[lim_pkg::CTRL_GIE] = 1'b1;
			end
			LIM_GIE_CLEAR: begin
				next_global_irq_control_reg[lim_pkg::CTRL_GIE] = 1'b0;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			global_irq_control_reg <= lim_pkg::ZERO8;
		end else begin
			global_irq_control_reg <= next_global_irq_control_reg;
		end
	end

	// request view follows routed levels, unmasked
	always_comb begin
		next_level_req_reg = level_req;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_req_reg <= '0;
		end else begin
			level_req_reg <= next_level_req_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request, mask and control register read values
	assign rd_req_val  = 8'(level_req_reg);
	assign rd_mask_val = level_mask_reg;
	assign rd_ctrl_val = global_irq_control_reg & lim_pkg::CTRL_MASK;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		reg_rdata = lim_pkg::ZERO8;
		reg_hit   = 1'b0;
		if (reg_rd) begin
			unique case (reg_sel(reg_addr))
				LIM_SEL_REQ: begin
					reg_rdata = rd_req_val;
					reg_hit   = 1'b1;
				end
				LIM_SEL_MASK: begin
					reg_rdata = rd_mask_val;
					reg_hit   = 1'b1;
				end
				LIM_SEL_CTRL: begin
					reg_rdata = rd_ctrl_val;
					reg_hit   = 1'b1;
				end
				LIM_SEL_NONE: begin
					reg_rdata = lim_pkg::ZERO8;
					reg_hit   = 1'b0;
				end
			endcase
		end
	end
endmodule : lim_irq_ctrl

`default_nettype wire

// *** src/lim_level_map.sv ***
// Routes gated source requests onto the eight request levels
`default_nettype none

module lim_level_map #(
	parameter int NSRC = lim_pkg::NUM_SOURCES,
	parameter int NLVL = lim_pkg::NUM_LEVELS
) (
	input  wire logic [NSRC-1:0] src_req,
	input  wire logic [NSRC-1:0] src_en,
	output logic      [NLVL-1:0] level_req
);
	always_comb begin
		level_req = '0;
		for (int s = 0; s < NSRC; s++) begin
			if (src_req[s] && src_en[s]) begin
				level_req[lim_pkg::SRC_LEVEL[s]] = 1'b1;
			end
		end
	end
endmodule : lim_level_map

`default_nettype wire

// *** src/lim_pkg.sv ***
// Constants and types for the level interrupt mask and global enable block
// Operation
// - Control register at DEH, set 1
// - Reset clears fast and global enable bits
// - Enable instruction sets, disable clears bit 0
// - Bit 0 low blocks all interrupt processing
// - Bit 1 enables fast interrupt processing
// - Bits 4..2 select fast level 0..7
// - Eight-bit level mask at DDH, read/write
// - Mask undefined at reset; software initialises it
// - Mask bit n controls level n
// - Mask zero blocks level; one allows service
// - Source enable gates each request
// - Timers A,B,0 and misc routed levels 0,1,2,4
// - Timer 1 and 2 events to level 3
// - Both UART channels to level 5
// - Pin interrupts to levels 6, 7; F6H pending
// - Read-only request register at DCH, reset clear
// - Accept clears bit 0; return sets it
// - Lowest vector first within one level
// - Acknowledge only when all conditions hold
`default_nettype none

package lim_pkg;
	localparam int        NUM_LEVELS   = 8;
	localparam int        NUM_SOURCES  = 26;
	localparam logic [7:0] ADDR_REQ    = 8'hdc;
	localparam logic [7:0] ADDR_MASK   = 8'hdd;
	localparam logic [7:0] ADDR_CTRL   = 8'hde;
	localparam logic [7:0] ADDR_PINPND = 8'hf6;
	localparam int        CTRL_GIE     = 0;
	localparam int        CTRL_FIE     = 1;
	localparam int        CTRL_FLV_LO  = 2;
	localparam int        CTRL_FLV_HI  = 4;
	localparam logic [7:0] CTRL_MASK   = 8'h1f;
	localparam logic [7:0] ZERO8       = 8'h00;
	// Source index to level; index order is vector order within a level
	localparam logic [2:0] SRC_LEVEL [NUM_SOURCES] = '{
		3'h0, 3'h0, 3'h0,
		3'h1,
		3'h2, 3'h2,
		3'h3, 3'h3, 3'h3, 3'h3,
		3'h4, 3'h4, 3'h4, 3'h4,
		3'h5, 3'h5, 3'h5, 3'h5,
		3'h6, 3'h6, 3'h6, 3'h6,
		3'h7, 3'h7, 3'h7, 3'h7
	};
	localparam int        PIN_SRC_BASE = 18;
	localparam int        NUM_PINS     = 8;
endpackage : lim_pkg

`default_nettype wire

// *** src/lim_src_pick.sv ***
// Picks the lowest-indexed pending source of a chosen level
`default_nettype none

module lim_src_pick #(
	parameter int NSRC = lim_pkg::NUM_SOURCES
) (
	input  wire logic [NSRC-1:0] src_live,
	input  wire logic [2:0]      level,
	output logic      [4:0]      src_idx,
	output logic                 found
);
	always_comb begin
		src_idx = 5'h00;
		found   = 1'b0;
		for (int s = NSRC - 1; s >= 0; s--) begin
			if (src_live[s] && lim_pkg::SRC_LEVEL[s] == level) begin
				src_idx = 5'(s);
				found   = 1'b1;
			end
		end
	end
endmodule : lim_src_pick

`default_nettype wire

// *** tb/lim_core_model.sv ***
// Core model that returns from each accepted interrupt after a delay
`default_nettype none

module lim_core_model #(
	parameter int RET_DELAY = 4
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic irq_take,
	output logic      irq_return_instr
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 0;
			irq_return_instr <= 1'b0;
		end else begin
			irq_return_instr <= cnt == 1;
			cnt <= irq_take ? RET_DELAY : cnt == 0 ? 0 : cnt - 1;
		end
	end
endmodule : lim_core_model

`default_nettype wire

// *** tb/lim_irq_ctrl_bench.sv ***
// Bench for the level interrupt gate
`default_nettype none

module lim_irq_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        irq_enable_instr = 1'b0, irq_disable_instr = 1'b0, instr_end = 1'b0;
	logic        irq_return_instr, reg_hit, irq_take, irq_fast, global_enable, fast_enable;
	logic [2:0]  fast_level;
	logic [4:0]  irq_src;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, level_win = 8'h00, reg_rdata, level_service;
	logic [25:0] src_req = '0, src_en = '0;
	logic [31:0] seed = 32'h0000ccc8, m, q;
	int          err_count = 0, num_checks = 0, cyc = 0, lr, cand, lv, sv;
	lim_irq_ctrl DUT (.core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_hit, .irq_enable_instr, .irq_disable_instr, .irq_return_instr, .src_req, .src_en,
		.level_win, .instr_end, .irq_take, .irq_src, .irq_fast, .level_service,
		.global_enable, .fast_enable, .fast_level);
	lim_core_model #(.RET_DELAY(4)) u_core (.core_clk, .sys_rst, .irq_take, .irq_return_instr);
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			give_verdict();
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic int lvl(int s);
		return s < 3 ? 0 : s == 3 ? 1 : s < 6 ? 2 : s < 10 ? 3 : (s - 10) / 4 + 4;
	endfunction : lvl
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(negedge core_clk);
		chk(reg_rdata, e);
		chk(reg_hit, a inside {8'hdc, 8'hdd, 8'hde});
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic ins(input logic dis);
		@(posedge core_clk);
		irq_enable_instr <= !dis;
		irq_disable_instr <= dis;
		@(posedge core_clk);
		irq_enable_instr <= 1'b0;
		irq_disable_instr <= 1'b0;
	endtask : ins
	task automatic give_verdict();
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'hde, 8'h00);
		rd(8'hdc, 8'h00);
		rd(8'h5a, 8'h00);
		q = xs();
		wr(8'hdd, q[7:0]);
		rd(8'hdd, q[7:0]);
		for (int i = 0; i < 8; i++) begin
			wr(8'hde, {3'h7, i[2:0], 2'h2});
			rd(8'hde, {3'h0, i[2:0], 2'h2});
		end
		src_en <= '1;
		for (int s = 0; s < 26; s++) begin
			src_req <= 26'h1 << s;
			rd(8'hdc, 8'h1 << lvl(s));
		end
		src_en <= '0;
		rd(8'hdc, 8'h00);
		ins(1'b0);
		rd(8'hde, 8'h1f);
		sys_rst <= 1'b1;
		@(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'hde, 8'h00);
		repeat (40) begin
			// Sources and mask change only while globally disabled
			ins(1'b1);
			q = xs();
			wr(8'hdd, q[7:0]);
			wr(8'hde, {q[15:9], 1'b0});
			rd(8'hde, {3'h0, q[12:9], 1'b0});
			m = xs();
			src_req <= m[25:0];
			m = xs();
			src_en <= m[25:0];
			level_win <= m[31:24];
			if (m[30])
				ins(1'b0);
			@(posedge core_clk);
			instr_end <= 1'b1;
			@(negedge core_clk);
			lr = 0;
			for (int s = 0; s < 26; s++)
				if (src_req[s] && src_en[s])
					lr = lr | (1 << lvl(s));
			cand = lr & q[7:0] & level_win;
			lv = 0;
			while (cand != 0 && !cand[lv])
				lv++;
			sv = 0;
			while (cand != 0 && !(src_req[sv] && src_en[sv] && lvl(sv) == lv))
				sv++;
			chk(level_service, lr[7:0] & q[7:0]);
			chk(irq_take, m[30] && cand != 0);
			if (m[30] && cand != 0) begin
				chk(irq_src, sv[7:0]);
				chk(irq_fast, q[9] && lv == q[12:10]);
			end
			@(posedge core_clk);
			instr_end <= 1'b0;
			@(negedge core_clk);
			chk(global_enable, m[30] && cand == 0);
			repeat (8) if (global_enable !== 1'b1) @(negedge core_clk);
			chk(global_enable, m[30]);
		end
		give_verdict();
	end
endmodule : lim_irq_ctrl_bench

bind lim_irq_ctrl lim_properties u_prop (.core_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
	.reg_hit, .irq_enable_instr, .irq_disable_instr, .irq_return_instr, .instr_end, .irq_take,
	.global_enable, .fast_enable, .fast_level);

`default_nettype wire

// *** tb/lim_properties.sv ***
// Port checker for the level interrupt gate
`default_nettype none

module lim_properties (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_hit,
	input wire logic       irq_enable_instr,
	input wire logic       irq_disable_instr,
	input wire logic       irq_return_instr,
	input wire logic       instr_end,
	input wire logic       irq_take,
	input wire logic       global_enable,
	input wire logic       fast_enable,
	input wire logic [2:0] fast_level
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// Set events outrank the accept clear
	sequence s_quiet_take;
		irq_take && !irq_enable_instr && !irq_return_instr;
	endsequence
	sequence s_ret;
		irq_return_instr;
	endsequence
	a_take_gated: assert property (irq_take |-> global_enable && instr_end)
		else $error("take ungated");
	a_take_clears: assert property (s_quiet_take |=> !global_enable)
		else $error("take kept enable");
	a_return_sets: assert property (s_ret |=> global_enable)
		else $error("return no set");
	a_enable_sets: assert property (irq_enable_instr |=> global_enable)
		else $error("enable no set");
	a_disable_clears: assert property (irq_disable_instr && !irq_enable_instr
		&& !irq_return_instr |=> !global_enable)
		else $error("disable no clear");
	a_ctrl_read: assert property (reg_rd && reg_addr == 8'hde |->
		reg_rdata == {3'h0, fast_level, fast_enable, global_enable})
		else $error("control read bad");
	a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'hdc, 8'hdd, 8'hde})
		|-> reg_rdata == 8'h00 && !reg_hit)
		else $error("unmapped read bad");
	a_mapped_hit: assert property (reg_rd && reg_addr inside {8'hdc, 8'hdd, 8'hde}
		|-> reg_hit)
		else $error("mapped read no hit");
endmodule : lim_properties

`default_nettype wire
